//--- rtl/rph_pkg.sv
package rph_pkg;
   // ==========================================================
   // Register word indices on the AXI4-Lite bus (taken from address bits 17:2)
   localparam logic [15:0] SYNC_HIGH_ADDR  = 16'hdf00;
   localparam logic [15:0] SYNC_LOW_ADDR   = 16'hdf01;
   localparam logic [15:0] PKT_LEN_IDX     = 16'hdf02;
   localparam logic [15:0] PKT_CTRL_HI_IDX = 16'hdf03;
   localparam logic [15:0] PKT_CTRL_LO_IDX = 16'hdf04;
   localparam logic [15:0] OWN_ADDR_IDX    = 16'hdf05;
   localparam logic [15:0] CHANNEL_INDEX_IDX        = 16'hdf06;
   localparam logic [15:0] SPACING_IDX     = 16'hdf10;
   localparam logic [15:0] IRQ_STAT_IDX    = 16'hdf20;
   localparam logic [15:0] IRQ_EN_IDX      = 16'hdf21;
   localparam logic [15:0] IRQ_CLR_IDX     = 16'hdf22;
   localparam logic [15:0] FREQ_IDX        = 16'hdf23;
   // ==========================================================
   // Reset values
   localparam logic [7:0]  PKT_LEN_RST     = 8'hff;
   localparam logic [7:0]  CTRL_HI_RST     = 8'h04;
   localparam logic [7:0]  CTRL_LO_RST     = 8'h45;
   localparam logic [7:0]  SYNC_HIGH_RST   = 8'hd3;
   localparam logic [7:0]  SYNC_LOW_RST    = 8'h91;
   localparam logic [7:0]  SPACING_RST     = 8'h01;
   localparam logic [23:0] BASE_FREQ_RST   = 24'h000000;
   // ==========================================================
   // Field positions
   localparam int PQT_LSB   = 5;
   localparam int APP_BIT   = 2;
   localparam int WHITE_BIT = 6;
   localparam int FMT_LSB   = 4;
   localparam int LEG_BIT   = 3;
   localparam int CRC_BIT   = 2;
   // ==========================================================
   // Encodings and counts
   localparam logic [1:0] LEN_FIXED = 2'h0;
   localparam logic [1:0] LEN_VAR   = 2'h1;
   localparam logic [1:0] FMT_PN9   = 2'h2;
   localparam logic [1:0] ADR_NONE  = 2'h0;
   localparam logic [1:0] ADR_ZERO  = 2'h2;
   localparam logic [1:0] ADR_BOTH  = 2'h3;
   localparam logic [7:0] PQ_DROP   = 8'h08;
   localparam logic [2:0] NUM_IRQ   = 3'h3;
   localparam int         IRQ_PKT   = 0;
   localparam int         IRQ_DROP  = 1;
   localparam int         IRQ_SYNC  = 2;

   typedef enum logic [5:0] {
      ST_HUNT = 6'h01, ST_LEN = 6'h02, ST_ADR = 6'h04,
      ST_PAY  = 6'h08, ST_CRC = 6'h10, ST_STAT = 6'h20
   } rph_rx_t;

   typedef struct packed {
      logic [7:0] data;
      logic       valid;
      logic       last;
   } rph_byte_t;
endpackage : rph_pkg

//--- rtl/rph_crc_whiten.sv
`timescale 1ns/100ps
// ==========================================================
// Bitwise CRC16 and PN9 whitening step on one byte
module rph_crc_whiten
   import rph_pkg::*;
(
   input  wire logic [7:0]  dataIn,
   input  wire logic [15:0] crcIn,
   input  wire logic [8:0]  pnIn,
   input  wire logic        legacy,
   output logic      [15:0] crcOut,
   output logic      [8:0]  pnOut,
   output logic      [7:0]  pnByte
);
   // Byte-wide CRC (poly 0x8005) and eight-step PN9 advance
   always_comb begin
      logic [15:0] c;
      logic [8:0]  p;
      logic        fb;
      fb = 1'b0;
      c = crcIn;
      p = pnIn;
      pnByte = pnIn[7:0];
      for (int i = 7; i >= 0; i--) begin
         fb = (legacy ? dataIn[7 - i] : dataIn[i]) ^ c[15];
         c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      end
      for (int j = 0; j < 8; j++) begin
         p = {p[0] ^ p[5], p[8:1]};
      end
      crcOut = c;
      pnOut = p;
   end
endmodule : rph_crc_whiten

//--- rtl/rph_packet_handler.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
// Contract
// - fixed mode uses packet length register as exact payload length
// - variable mode treats packet length register as maximum length
// - preamble counter +1 on bit change, -8 on repeat
// - sync accepted only when counter reaches 4*threshold; zero threshold always
// - status enable appends two bytes: strength, quality, CRC good
// - address mode 00 none, 01 own, 10 plus zero, 11 both
// - mode 11 accepts own, 0x00, 0xff; mode 10 own and 0x00
// - whitening bit defaults on, works only with legacy CRC cleared
// - format 10 sends PN9 data on transmit, normal in receive
// - CRC enable computes on transmit and checks on receive
// - length config 00 fixed, 01 from first byte after sync
// - received address compared with device address register
// - frequency equals base plus channel number times spacing
// - sync word is sixteen bits from high and low registers
module rph_packet_handler
   import rph_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        clkEn,
   input  wire logic [31:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic      [1:0]  bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [31:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic      [31:0] rdata,
   output logic      [1:0]  rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        rxBit,
   input  wire logic        rxBitValid,
   input  wire logic [7:0]  rssi,
   input  wire logic [7:0]  lqi,
   input  wire logic        txByteReq,
   output rph_byte_t        txByte,
   output rph_byte_t        rxByte,
   output logic      [31:0] frequency,
   output logic             irq
);
   // ==========================================================
   // State
   typedef struct packed {
      logic        awDone, wDone, bv, rv;
      logic [15:0] wAddr;
      logic [31:0] wData;
      logic [31:0] rData;
      logic [1:0]  bResp, rResp;
      logic [7:0]  packet_length, ctrlHi, ctrlLo, ownAdr, channel_index, spacing, syncH, syncL;
      logic [23:0] baseFreq;
      logic [2:0]  irqStat, irqEn;
      logic        irqOut;
      logic [7:0]  pq;
      logic        lastBit;
      logic [15:0] shift;
      logic [2:0]  bitCnt;
      rph_rx_t     rxState;
      logic [7:0]  remain;
      logic [15:0] crc;
      logic [8:0]  pn;
      logic [1:0]  statCnt;
      logic        crcGood;
      logic [15:0] txCrc;
      logic [8:0]  txPn;
      logic [8:0]  txCnt;
      rph_byte_t   txOut, rxOut;
      logic [31:0] freqOut;
   } rph_state_t;

   rph_state_t st, next_st;

   logic [7:0]  rxRaw, rxPlain, txData;
   logic [15:0] crcNext, txCrcNext;
   logic [8:0]  pnNext, txPnNext;
   logic [7:0]  pnByte, txPnByte;
   logic        whiteOn, crcOn, sawByte;

   assign whiteOn = st.ctrlLo[WHITE_BIT] && !st.ctrlLo[LEG_BIT];
   assign crcOn   = st.ctrlLo[CRC_BIT];
   assign rxRaw   = {st.shift[6:0], rxBit}; // Byte completes with the bit arriving now
   assign rxPlain = whiteOn ? (rxRaw ^ pnByte) : rxRaw;
   assign txData  = (st.ctrlLo[FMT_LSB +: 2] == FMT_PN9) ? txPnByte : st.txCnt[7:0];

   // ==========================================================
   // Separate CRC and whitening steppers for receive and transmit
   rph_crc_whiten uRxStep (
      .dataIn (rxPlain),
      .crcIn  (st.crc),
      .pnIn   (st.pn),
      .legacy (st.ctrlLo[LEG_BIT]),
      .crcOut (crcNext),
      .pnOut  (pnNext),
      .pnByte (pnByte)
   );
   rph_crc_whiten uTxStep (
      .dataIn (txData),
      .crcIn  (st.txCrc),
      .pnIn   (st.txPn),
      .legacy (st.ctrlLo[LEG_BIT]),
      .crcOut (txCrcNext),
      .pnOut  (txPnNext),
      .pnByte (txPnByte)
   );

   // Address filter decision
   function automatic logic adrPass(input logic [1:0] m, input logic [7:0] a,
                                    input logic [7:0] own);
      adrPass = (m == ADR_NONE) || (a == own)
             || (m[1] && a == 8'h00) || (m == ADR_BOTH && a == 8'hff);
   endfunction : adrPass

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic [15:0] ia;
      logic [2:0]  evt, clr;
      logic [7:0]  lenLimit;
      next_st = st;
      ia = 16'h0000;
      evt = 3'h0;
      clr = 3'h0;
      lenLimit = st.packet_length;
      sawByte = 1'b0;
      next_st.rxOut.valid = 1'b0;
      next_st.rxOut.last = 1'b0;
      next_st.txOut.valid = 1'b0;
      next_st.txOut.last = 1'b0;
      // Bus write channels
      if (awvalid && !st.awDone) begin
         next_st.awDone = 1'b1;
         next_st.wAddr = awaddr[17:2];
      end
      if (wvalid && !st.wDone) begin
         next_st.wDone = 1'b1;
         next_st.wData = wdata;
      end
      if (st.awDone && st.wDone && !st.bv) begin
         next_st.awDone = 1'b0;
         next_st.wDone = 1'b0;
         next_st.bv = 1'b1;
         next_st.bResp = 2'h0;
         if (wstrb[0]) begin
            unique case (st.wAddr)
               PKT_LEN_IDX:     next_st.packet_length = st.wData[7:0];
               PKT_CTRL_HI_IDX: next_st.ctrlHi = st.wData[7:0] & 8'he7;
               PKT_CTRL_LO_IDX: next_st.ctrlLo = st.wData[7:0] & 8'h7f;
               OWN_ADDR_IDX:    next_st.ownAdr = st.wData[7:0];
               CHANNEL_INDEX_IDX:        next_st.channel_index = st.wData[7:0];
               SPACING_IDX:     next_st.spacing = st.wData[7:0];
               SYNC_HIGH_ADDR:  next_st.syncH = st.wData[7:0];
               SYNC_LOW_ADDR:   next_st.syncL = st.wData[7:0];
               IRQ_EN_IDX:      next_st.irqEn = st.wData[2:0];
               IRQ_CLR_IDX:     clr = st.wData[2:0];
               FREQ_IDX:        next_st.baseFreq = st.wData[23:0];
               default:         next_st.bResp = 2'h2;
            endcase
         end
      end
      if (st.bv && bready) next_st.bv = 1'b0;
      // Bus read channel
      if (arvalid && !st.rv) begin
         ia = araddr[17:2];
         next_st.rv = 1'b1;
         next_st.rResp = 2'h0;
         next_st.rData = 32'h00000000;
         unique case (ia)
            PKT_LEN_IDX:     next_st.rData[7:0] = st.packet_length;
            PKT_CTRL_HI_IDX: next_st.rData[7:0] = st.ctrlHi;
            PKT_CTRL_LO_IDX: next_st.rData[7:0] = st.ctrlLo;
            OWN_ADDR_IDX:    next_st.rData[7:0] = st.ownAdr;
            CHANNEL_INDEX_IDX:        next_st.rData[7:0] = st.channel_index;
            SPACING_IDX:     next_st.rData[7:0] = st.spacing;
            SYNC_HIGH_ADDR:  next_st.rData[7:0] = st.syncH;
            SYNC_LOW_ADDR:   next_st.rData[7:0] = st.syncL;
            IRQ_STAT_IDX:    next_st.rData[2:0] = st.irqStat;
            IRQ_EN_IDX:      next_st.rData[2:0] = st.irqEn;
            IRQ_CLR_IDX:     next_st.rData = 32'h00000000;
            FREQ_IDX:        next_st.rData = st.freqOut;
            default:         next_st.rResp = 2'h2;
         endcase
      end
      if (st.rv && rready) next_st.rv = 1'b0;
      // Preamble quality counter, saturating at both ends
      if (rxBitValid) begin
         if (rxBit != st.lastBit)
            next_st.pq = (st.pq == 8'hff) ? st.pq : st.pq + 8'h01;
         else
            next_st.pq = (st.pq < PQ_DROP) ? 8'h00 : st.pq - PQ_DROP;
         next_st.lastBit = rxBit;
         next_st.shift = {st.shift[14:0], rxBit};
      end
      // Receive framing
      if (rxBitValid && st.rxState != ST_HUNT) begin
         next_st.bitCnt = st.bitCnt + 3'h1;
         sawByte = (st.bitCnt == 3'h7);
      end
      unique case (st.rxState)
         ST_HUNT: begin
            if (rxBitValid && {st.shift[14:0], rxBit} == {st.syncH, st.syncL}
                && {3'h0, st.pq} >= {st.ctrlHi[PQT_LSB +: 3], 2'h0}) begin
               evt[IRQ_SYNC] = 1'b1;
               next_st.bitCnt = 3'h0;
               next_st.crc = 16'hffff;
               next_st.pn = 9'h1ff;
               next_st.crcGood = 1'b1;
               next_st.statCnt = 2'h0;
               next_st.remain = st.packet_length;
               next_st.rxState = (st.ctrlLo[1:0] == LEN_VAR) ? ST_LEN
                               : (st.ctrlHi[1:0] != ADR_NONE) ? ST_ADR : ST_PAY;
            end
         end
         ST_LEN: if (sawByte) begin
            next_st.crc = crcNext;
            next_st.pn = pnNext;
            next_st.remain = rxPlain;
            if (rxPlain > lenLimit || rxPlain == 8'h00) begin
               evt[IRQ_DROP] = 1'b1;
               next_st.rxState = ST_HUNT;
            end else
               next_st.rxState = (st.ctrlHi[1:0] != ADR_NONE) ? ST_ADR : ST_PAY;
         end
         ST_ADR: if (sawByte) begin
            if (!adrPass(st.ctrlHi[1:0], rxPlain, st.ownAdr)) begin
               evt[IRQ_DROP] = 1'b1;
               next_st.rxState = ST_HUNT;
            end else begin
               next_st.crc = crcNext;
               next_st.pn = pnNext;
               next_st.remain = st.remain - 8'h01;
               next_st.rxOut = '{data: rxPlain, valid: 1'b1, last: 1'b0};
               next_st.rxState = (st.remain == 8'h01) ?
                                 (crcOn ? ST_CRC : ST_STAT) : ST_PAY;
            end
         end
         ST_PAY: if (sawByte) begin
            next_st.crc = crcNext;
            next_st.pn = pnNext;
            next_st.remain = st.remain - 8'h01;
            next_st.rxOut = '{data: rxPlain, valid: 1'b1, last: 1'b0};
            if (st.remain == 8'h01) next_st.rxState = crcOn ? ST_CRC : ST_STAT;
         end
         ST_CRC: if (sawByte) begin
            next_st.crc = crcNext;
            next_st.pn = pnNext;
            next_st.statCnt = st.statCnt + 2'h1;
            if (st.statCnt == 2'h1) begin
               next_st.crcGood = (crcNext == 16'h0000);
               next_st.statCnt = 2'h0;
               next_st.rxState = ST_STAT;
            end
         end
         ST_STAT: begin
            next_st.statCnt = st.statCnt + 2'h1;
            if (!st.ctrlHi[APP_BIT] || st.statCnt == 2'h1) begin
               next_st.rxState = ST_HUNT;
               evt[IRQ_PKT] = 1'b1;
            end
            if (st.ctrlHi[APP_BIT])
               next_st.rxOut = '{data: (st.statCnt == 2'h0) ? rssi
                                       : {st.crcGood, lqi[6:0]},
                                 valid: 1'b1, last: (st.statCnt == 2'h1)};
         end
         default: next_st.rxState = ST_HUNT;
      endcase
      // Transmit byte source: payload, then CRC
      if (txByteReq) begin
         if (st.txCnt < {1'b0, st.packet_length}) begin
            next_st.txOut = '{data: whiteOn ? (txData ^ txPnByte) : txData, valid: 1'b1,
                              last: !crcOn && st.txCnt == {1'b0, st.packet_length} - 9'h001};
            next_st.txCrc = txCrcNext;
            next_st.txPn = txPnNext;
            next_st.txCnt = st.txCnt + 9'h001;
         end else if (crcOn && st.txCnt < {1'b0, st.packet_length} + 9'h002) begin
            next_st.txOut = '{data: (st.txCnt == {1'b0, st.packet_length}) ? st.txCrc[15:8]
                                    : st.txCrc[7:0], valid: 1'b1,
                              last: st.txCnt != {1'b0, st.packet_length}};
            next_st.txCnt = st.txCnt + 9'h001;
         end else begin
            next_st.txCnt = 9'h000;
            next_st.txCrc = 16'hffff;
            next_st.txPn = 9'h1ff;
         end
      end
      // Sticky events: set wins over clear
      next_st.irqStat = (st.irqStat & ~clr) | evt;
      next_st.irqOut = |(next_st.irqStat & st.irqEn);
      next_st.freqOut = {8'h00, st.baseFreq} + 32'(st.channel_index) * 32'(st.spacing);
   end

   // ==========================================================
   // State register with clock enable
   always_ff @(posedge clock) begin
      if (rst) begin
         st <= '0;
         st.packet_length <= PKT_LEN_RST;
         st.ctrlHi <= CTRL_HI_RST;
         st.ctrlLo <= CTRL_LO_RST;
         st.syncH <= SYNC_HIGH_RST;
         st.syncL <= SYNC_LOW_RST;
         st.spacing <= SPACING_RST;
         st.baseFreq <= BASE_FREQ_RST;
         st.rxState <= ST_HUNT;
         st.txCrc <= 16'hffff;
         st.txPn <= 9'h1ff;
      end else if (clkEn) begin
         st <= next_st;
      end
   end

   // Outputs straight from state flops
   assign awready = !st.awDone;
   assign wready = !st.wDone;
   assign bvalid = st.bv;
   assign bresp = st.bResp;
   assign arready = !st.rv;
   assign rvalid = st.rv;
   assign rdata = st.rData;
   assign rresp = st.rResp;
   assign txByte = st.txOut;
   assign rxByte = st.rxOut;
   assign frequency = st.freqOut;
   assign irq = st.irqOut;

   // ==========================================================
   // Checks
   property p_varMax;
      @(posedge clock) disable iff (rst)
      (clkEn && st.rxState == ST_LEN && sawByte && rxPlain > st.packet_length)
         |=> st.rxState == ST_HUNT;
   endproperty
   a_varMax: assert property (p_varMax) else $error("oversized length kept");
   property p_pqDrop;
      @(posedge clock) disable iff (rst)
      (clkEn && rxBitValid && rxBit == st.lastBit && st.pq >= 8'h08)
         |=> st.pq == $past(st.pq) - 8'h08;
   endproperty
   a_pqDrop: assert property (p_pqDrop) else $error("quality drop wrong");
   property p_adrDrop;
      @(posedge clock) disable iff (rst)
      (clkEn && st.rxState == ST_ADR && sawByte && !adrPass(st.ctrlHi[1:0], rxPlain, st.ownAdr))
         |=> !st.rxOut.valid && st.rxState == ST_HUNT;
   endproperty
   a_adrDrop: assert property (p_adrDrop) else $error("bad address delivered");
   property p_fixedLen;
      @(posedge clock) disable iff (rst)
      (clkEn && st.rxState == ST_HUNT && next_st.rxState == ST_PAY) |=> st.remain == $past(st.packet_length);
   endproperty
   a_fixedLen: assert property (p_fixedLen) else $error("fixed length wrong");
   property p_freq;
      @(posedge clock) disable iff (rst)
      clkEn ##1 clkEn |=> frequency == $past({8'h00, st.baseFreq} + 32'(st.channel_index) * 32'(st.spacing), 1);
   endproperty
   a_freq: assert property (p_freq) else $error("frequency wrong");
   property p_whiteLeg;
      @(posedge clock) disable iff (rst) st.ctrlLo[LEG_BIT] |-> !whiteOn;
   endproperty
   a_whiteLeg: assert property (p_whiteLeg) else $error("whitening with legacy CRC");
   property p_pqGate;
      @(posedge clock) disable iff (rst)
      (clkEn && st.rxState == ST_HUNT && {3'h0, st.pq} < {st.ctrlHi[7:5], 2'h0}) |=> st.rxState == ST_HUNT;
   endproperty
   a_pqGate: assert property (p_pqGate) else $error("sync accepted below quality");
   property p_noStat;
      @(posedge clock) disable iff (rst)
      (clkEn && st.rxState == ST_STAT && !st.ctrlHi[APP_BIT]) |=> !st.rxOut.valid;
   endproperty
   a_noStat: assert property (p_noStat) else $error("status bytes without enable");
endmodule : rph_packet_handler

//--- dv/rph_radio_model.sv
`timescale 1ns/100ps
// ==========================================================
// Remote transmitter: serial frames, MSB first, one bit per strobe
module rph_radio_model
   import rph_pkg::*;
(
   output logic rxBit,
   output logic rxBitValid,
   input  wire logic clock
);
   // Line is quiet before the first frame
   initial begin
      rxBit      = 1'b0;
      rxBitValid = 1'b0;
   end

   // Preamble bytes, sixteen-bit sync word, then the body; gap slows the bit rate
   task automatic send_frame(input logic [7:0] pre, input int npre,
                             input logic [7:0] body[$], input int gap);
      logic [7:0] q[$];
      q = {};
      repeat (npre) q.push_back(pre);
      q.push_back(SYNC_HIGH_RST);
      q.push_back(SYNC_LOW_RST);
      q = {q, body};
      @(posedge clock);
      foreach (q[i]) for (int b = 7; b >= 0; b--) begin
         rxBit      <= q[i][b];
         rxBitValid <= 1'b1;
         @(posedge clock);
         if (gap > 0) begin
            rxBitValid <= 1'b0;
            rxBit      <= ~q[i][b]; // Released line shows the inverse
            repeat (gap) @(posedge clock);
         end
      end
      rxBitValid <= 1'b0;
      rxBit      <= ~q[q.size()-1][0];
   endtask : send_frame
endmodule : rph_radio_model

//--- dv/radio_packet_handler_config_tb.sv
`timescale 1ns/100ps
module radio_packet_handler_config_tb
   import rph_pkg::*;
();
   // ==========================================================
   // Signals
   logic        clock, rst, clkEn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq, txByteReq;
   logic        rxBit, rxBitValid, txLast[$];
   logic [31:0] awaddr, wdata, araddr, rdata, frequency, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic [7:0]  rssi, lqi, addr, rxq[$], txq[$];
   logic [7:0]  sel[4] = '{8'h5a, 8'h00, 8'hff, 8'h33};
   rph_byte_t   txByte, rxByte;
   int          num_errors, checks_done, cycles;

   rph_packet_handler DUT (.clock(clock), .rst(rst), .clkEn(clkEn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .rxBit(rxBit), .rxBitValid(rxBitValid), .rssi(rssi), .lqi(lqi),
      .txByteReq(txByteReq), .txByte(txByte), .rxByte(rxByte), .frequency(frequency),
      .irq(irq));
   rph_radio_model radio (.clock(clock), .rxBit(rxBit), .rxBitValid(rxBitValid));

   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Collect delivered bytes; cut a hang short
   always @(posedge clock) begin
      if (rxByte.valid === 1'b1) rxq.push_back(rxByte.data);
      if (txByte.valid === 1'b1) txq.push_back(txByte.data);
      if (txByte.valid === 1'b1) txLast.push_back(txByte.last);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ==========================================================
   // Tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [15:0] idx, input logic [7:0] val);
      @(posedge clock);
      awaddr  <= {14'h0, idx, 2'b00};
      wdata   <= {24'h0, val};
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [15:0] idx, input logic [31:0] exp, input string msg);
      @(posedge clock);
      araddr  <= {14'h0, idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      check(rd, exp, msg);
   endtask : reg_rd

   task automatic rx_frame(input logic [7:0] pre, input int npre, input logic [7:0] body[$],
                           input int gap, input int expCount, input string msg);
      rxq = {};
      radio.send_frame(pre, npre, body, gap);
      repeat (60) @(posedge clock);
      check(32'(rxq.size()), 32'(expCount), msg);
   endtask : rx_frame

   task automatic tx_req(input int n);
      txq = {};
      txLast = {};
      repeat (n) begin
         @(posedge clock);
         txByteReq <= 1'b1;
         @(posedge clock);
         txByteReq <= 1'b0;
         repeat (6) @(posedge clock);
      end
   endtask : tx_req

   function automatic logic [7:0] pn9_byte(input int k);
      logic [8:0] s;
      s = 9'h1ff;
      repeat (k) repeat (8) s = {s[0] ^ s[5], s[8:1]};
      return s[7:0];
   endfunction : pn9_byte

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up

   // ==========================================================
   // Test sequence
   initial begin
      {rst, clkEn, awvalid, wvalid, bready, arvalid, rready, txByteReq} = 8'hc0;
      {awaddr, wdata, araddr, wstrb} = '0;
      rssi = 8'h9c;
      lqi = 8'hb7;
      {cycles, num_errors, checks_done} = '0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      reg_rd(PKT_LEN_IDX, 32'hff, "length reset");
      reg_rd(PKT_CTRL_HI_IDX, 32'h04, "control high reset");
      reg_rd(PKT_CTRL_LO_IDX, 32'h45, "control low reset");
      reg_rd(OWN_ADDR_IDX, 32'h00, "address reset");
      reg_rd(CHANNEL_INDEX_IDX, 32'h00, "channel reset");
      reg_rd(16'hdf40, 32'h0, "unmapped data");
      check(32'(resp), 32'h2, "unmapped response");
      reg_wr(CHANNEL_INDEX_IDX, 8'hff);
      reg_wr(SPACING_IDX, 8'h03);
      repeat (4) @(posedge clock);
      check(frequency, 32'(BASE_FREQ_RST) + 32'd765, "frequency");
      $display("Test registers done");
      reg_wr(PKT_CTRL_LO_IDX, 8'h01);
      reg_wr(OWN_ADDR_IDX, 8'h5a);
      reg_wr(PKT_LEN_IDX, 8'h04);
      rx_frame(8'haa, 4, {8'h04, 8'h5a, 8'h11, 8'h22, 8'h33}, 0, 6, "max length");
      check(32'(rxq[0]), 32'h5a, "first body byte");
      check(32'(rxq[4]), 32'(rssi), "strength byte");
      check(32'(rxq[5][6:0]), 32'(lqi[6:0]), "quality byte");
      rx_frame(8'haa, 4, {8'h05, 8'h5a, 8'h11, 8'h22, 8'h33, 8'h44}, 1, 0, "oversize");
      for (int m = 0; m < 4; m++) for (int a = 0; a < 4; a++) begin
         addr = sel[a];
         reg_wr(PKT_CTRL_HI_IDX, 8'h04 | 8'(m));
         rx_frame(8'haa, 4, {8'h02, addr, 8'hc3}, m % 2, (m == 0 || addr == 8'h5a ||
            (m >= 2 && addr == 8'h00) || (m == 3 && addr == 8'hff)) ? 4 : 0,
            "address filter");
      end
      $display("Test receive variable done");
      reg_wr(PKT_CTRL_HI_IDX, 8'h00);
      reg_wr(PKT_CTRL_LO_IDX, 8'h00);
      reg_wr(PKT_LEN_IDX, 8'h03);
      rx_frame(8'haa, 4, {8'h21, 8'h43, 8'h65}, 0, 3, "fixed no status");
      check(32'(rxq[2]), 32'h65, "fixed last byte");
      reg_wr(PKT_CTRL_HI_IDX, 8'h24);
      rx_frame(8'h00, 2, {8'h21, 8'h43, 8'h65}, 0, 0, "weak preamble");
      reg_wr(IRQ_CLR_IDX, 8'h07);
      reg_rd(IRQ_STAT_IDX, 32'h0, "status cleared");
      rx_frame(8'haa, 8, {8'h21, 8'h43, 8'h65}, 0, 5, "good preamble");
      reg_rd(IRQ_STAT_IDX, 32'h05, "status after packet");
      check(32'(irq), 32'h0, "irq masked");
      reg_wr(IRQ_EN_IDX, 8'h01);
      repeat (2) @(posedge clock);
      check(32'(irq), 32'h1, "irq raised");
      reg_wr(IRQ_CLR_IDX, 8'h01);
      repeat (2) @(posedge clock);
      check(32'(irq), 32'h0, "irq cleared");
      reg_rd(IRQ_STAT_IDX, 32'h04, "status after clear");
      $display("Test receive fixed done");
      reg_wr(PKT_CTRL_LO_IDX, 8'h04);
      tx_req(5);
      check(32'(txq.size()), 32'd5, "crc on count");
      check(32'({txLast[2], txLast[4]}), 32'h1, "crc on last");
      reg_wr(PKT_CTRL_LO_IDX, 8'h00);
      tx_req(4); // First request restarts the frame counter
      check(32'({txq.size() == 3, txLast[2]}), 32'h3, "crc off last");
      reg_wr(PKT_CTRL_LO_IDX, 8'h20);
      tx_req(4); // First request restarts the frame counter
      for (int k = 0; k < 3; k++) check(32'(txq[k]), 32'(pn9_byte(k)), "random data");
      $display("Test transmit done");
      wrap_up();
   end
endmodule : radio_packet_handler_config_tb
